// ==== src/iwu_core.sv ====
// Interrupt controller with external line detection, priority and wait mode
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "iwu_defines.svh"

module iwu_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] ext_pin_i,
    input wire logic [5:0] periph_event_i,
    input wire iwu_pkg::iwu_cpu_req_type cpu_req,
    output iwu_pkg::iwu_svc_type svc,
    output logic cpu_stop,
    output logic halt_wake
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] sens_reg;
    logic [7:0] pin_en_reg;
    logic [5:0] per_en_reg;
    logic [5:0] per_pend_reg;
    logic [5:0] per_arm_reg;
    logic [3:0] ext_lat_reg;
    iwu_pkg::iwu_state_type state_reg;
    logic [31:0] rdata_next;

    // The access commits in the cycle that ack is shown
    assign acc = wb_cyc_i && wb_stb_i && ack_reg;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    always_comb begin
        rdata_next = 32'h0;
        case (wb_adr_i)
            `IWU_ADR_SENS: rdata_next[7:0] = sens_reg;
            `IWU_ADR_PIN_EN: rdata_next[7:0] = pin_en_reg;
            `IWU_ADR_PER_EN: rdata_next[5:0] = per_en_reg;
            `IWU_ADR_PER_STAT: rdata_next[5:0] = per_pend_reg;
            `IWU_ADR_STATE: begin
                rdata_next[3:0] = ext_lat_reg;
                rdata_next[4] = (state_reg == iwu_pkg::IWU_WAIT);
                rdata_next[5] = cpu_req.i_bit;
            end
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else if (ce) begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            if (wb_cyc_i && wb_stb_i && !ack_reg) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sens_reg <= `IWU_RST_SENS;
        end else if (ce && wr && wb_adr_i == `IWU_ADR_SENS && cpu_req.i_bit) begin
            sens_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_en_reg <= `IWU_RST_PIN_EN;
            per_en_reg <= `IWU_RST_PER_EN;
        end else if (ce && wr) begin
            if (wb_adr_i == `IWU_ADR_PIN_EN) begin
                pin_en_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `IWU_ADR_PER_EN) begin
                per_en_reg <= wb_dat_i[5:0];
            end
        end
    end

    // ****************************************************************
    // External lines
    // ****************************************************************
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [3:0] line_lvl;
    logic [3:0] line_prev_reg;
    logic [3:0] edge_hit;
    logic [3:0] ext_req;
    logic [3:0] ext_clr;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_reg <= 8'hff;
            sync2_reg <= 8'hff;
            line_prev_reg <= 4'hf;
        end else if (ce) begin
            sync1_reg <= ext_pin_i;
            sync2_reg <= sync1_reg;
            line_prev_reg <= line_lvl;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_line
            logic [1:0] mode;
            logic [1:0] pins;
            logic rise;
            logic fall;
            assign pins = sync2_reg[2*gi+1:2*gi] | ~pin_en_reg[2*gi+1:2*gi];
            // NAND of enabled pins seen through an inverting detector input
            assign line_lvl[gi] = ~(~&pins);
            assign mode = sens_reg[2*gi+1:2*gi];
            assign rise = line_lvl[gi] && !line_prev_reg[gi];
            assign fall = !line_lvl[gi] && line_prev_reg[gi];
            always_comb begin
                case (mode)
                    `IWU_SENS_FALL_LOW: edge_hit[gi] = fall;
                    `IWU_SENS_RISE: edge_hit[gi] = rise;
                    `IWU_SENS_FALL: edge_hit[gi] = fall;
                    `IWU_SENS_BOTH: edge_hit[gi] = rise || fall;
                    default: edge_hit[gi] = 1'b0;
                endcase
            end
            assign ext_req[gi] = ext_lat_reg[gi] ||
                (mode == `IWU_SENS_FALL_LOW && !line_lvl[gi]);
        end
    endgenerate

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    logic [12:0] req_vec;
    logic win_any;
    logic [3:0] win_idx;
    logic take_now;
    logic take_trap;
    logic go_wait;
    logic [3:0] take_src;

    assign req_vec = {per_pend_reg & per_en_reg, 2'b00, ext_req, 1'b0};

    always_comb begin
        win_any = 1'b0;
        win_idx = 4'h0;
        for (int k = 12; k >= 1; k--) begin
            if (req_vec[k]) begin
                win_any = 1'b1;
                win_idx = 4'(k);
            end
        end
    end

    assign take_trap = state_reg == iwu_pkg::IWU_RUN && cpu_req.instr_end &&
        cpu_req.trap_exec;
    assign take_now = take_trap ||
        (state_reg == iwu_pkg::IWU_RUN && cpu_req.instr_end && win_any &&
        !cpu_req.i_bit) ||
        (state_reg == iwu_pkg::IWU_WAIT && win_any);
    assign take_src = take_trap ? `IWU_SRC_TRAP : win_idx;
    assign go_wait = state_reg == iwu_pkg::IWU_RUN && cpu_req.instr_end &&
        cpu_req.wait_for_interrupt_instruction && !take_now;

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            ext_clr[k] = take_now && take_src == `IWU_SRC_EXT_FIRST + 4'(k);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_lat_reg <= 4'h0;
        end else if (ce) begin
            // A new edge in the entry cycle stays latched
            ext_lat_reg <= (ext_lat_reg & ~ext_clr) | edge_hit;
        end
    end

    // ****************************************************************
    // Peripheral pending flags
    // ****************************************************************
    logic [5:0] per_clr;

    always_comb begin
        per_clr = 6'h00;
        if (wr && wb_adr_i == `IWU_ADR_PER_STAT) begin
            per_clr = ~wb_dat_i[5:0];
        end else if (acc && wb_adr_i == `IWU_ADR_PER_ASSOC) begin
            per_clr = per_arm_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            per_pend_reg <= 6'h00;
        end else if (ce) begin
            // Held until cleared whatever the mask and enables say
            per_pend_reg <= (per_pend_reg & ~per_clr) | periph_event_i;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            per_arm_reg <= 6'h00;
        end else if (ce) begin
            if (rd && wb_adr_i == `IWU_ADR_PER_STAT) begin
                per_arm_reg <= per_pend_reg;
            end else if (acc && wb_adr_i == `IWU_ADR_PER_ASSOC) begin
                per_arm_reg <= 6'h00;
            end
        end
    end

    // ****************************************************************
    // Service entry and wait mode
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= iwu_pkg::IWU_RUN;
        end else if (ce) begin
            case (state_reg)
                iwu_pkg::IWU_RUN: begin
                    if (go_wait) begin
                        state_reg <= iwu_pkg::IWU_WAIT;
                    end
                end
                iwu_pkg::IWU_WAIT: begin
                    if (win_any) begin
                        state_reg <= iwu_pkg::IWU_RUN;
                    end
                end
                default: state_reg <= iwu_pkg::IWU_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            svc <= '0;
        end else if (ce) begin
            svc.take <= take_now;
            svc.push_condition_code_register <= take_now;
            svc.set_i <= take_now;
            svc.clr_i <= go_wait;
            if (take_now) begin
                svc.source <= take_src;
                // Slot zero is unused, so numbered sources count down from below the trap
                svc.vector <= (take_src == `IWU_SRC_TRAP) ? `IWU_VEC_TRAP :
                    `IWU_VEC_SLOT0 - {11'h0, take_src, 1'b0};
            end
        end
    end

    assign cpu_stop = state_reg == iwu_pkg::IWU_WAIT;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halt_wake <= 1'b0;
        end else if (ce) begin
            halt_wake <= |(req_vec & `IWU_HALT_WAKE_MASK);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_trap_taken: assert property (ce && take_trap |=> svc.take && svc.vector == 16'hfffc)
        else $error("trap not serviced");
    chk_mask_blocks: assert property (ce && cpu_req.i_bit && state_reg == iwu_pkg::IWU_RUN
        && !cpu_req.trap_exec |=> !svc.take)
        else $error("vector taken with mask set");
    chk_edge_clear: assert property (ce && ext_clr[0] && !edge_hit[0] |=> !ext_lat_reg[0])
        else $error("edge latch not cleared on entry");
    chk_sens_locked: assert property (ce && wr && wb_adr_i == `IWU_ADR_SENS
        && !cpu_req.i_bit |=> $stable(sens_reg))
        else $error("sensitivity written while mask clear");
    chk_sens_reset: assert property ($fell(rst) |-> sens_reg == 8'h00)
        else $error("sensitivity reset value wrong");
    chk_pend_kept: assert property (ce && per_pend_reg[0] && !per_clr[0]
        |=> per_pend_reg[0])
        else $error("pending peripheral request lost");
    chk_wait_entry: assert property (ce && go_wait |=> cpu_stop && svc.clr_i
        ##1 !svc.clr_i || !ce)
        else $error("wait entry wrong");
    chk_wait_wake: assert property (ce && cpu_stop && win_any |=> !cpu_stop && svc.take)
        else $error("wait not ended by request");
    chk_vec_addr: assert property (svc.take |-> (svc.source == 4'h0
        ? svc.vector == 16'hfffc : svc.vector == 16'hfffa - 16'(svc.source) * 16'h2))
        else $error("vector address wrong");
    chk_prio_order: assert property (win_any |-> req_vec[win_idx]
        && (req_vec & ((13'h1 << win_idx) - 13'h1)) == 13'h0)
        else $error("priority order wrong");
    chk_halt_wake: assert property (ce && req_vec[8] && !req_vec[10]
        && (req_vec & 13'h1a9e) == 13'h0 |=> !halt_wake)
        else $error("compare request woke halt");
    chk_ext_wake: assert property (ce && |req_vec[4:1] |=> halt_wake)
        else $error("external request did not wake halt");
    chk_low_blocks: assert property (ce && !line_lvl[1] && !ext_lat_reg[1]
        && sens_reg[3:2] == `IWU_SENS_RISE |=> !ext_lat_reg[1])
        else $error("low combined pin let a rising request through");
    chk_per_gate: assert property (ce && state_reg == iwu_pkg::IWU_RUN && !cpu_req.i_bit
        && !cpu_req.trap_exec && ext_req == 4'h0 && (per_pend_reg & per_en_reg) == 6'h00
        |=> !svc.take)
        else $error("peripheral taken without enable");
    chk_pend_clear: assert property (ce && wr && wb_adr_i == `IWU_ADR_PER_STAT
        && !wb_dat_i[0] && !periph_event_i[0] |=> !per_pend_reg[0])
        else $error("clearing write left request pending");
    chk_sens_write: assert property (ce && wr && wb_adr_i == `IWU_ADR_SENS
        && cpu_req.i_bit |=> sens_reg == $past(wb_dat_i[7:0]))
        else $error("sensitivity write with mask set lost");
    chk_wait_hold: assert property (ce && cpu_stop && !win_any |=> cpu_stop)
        else $error("wait left without a request");

    cov_trap: cover property (ce && take_trap);
    cov_wait_wake: cover property (ce && cpu_stop && win_any);
    cov_ext_edge: cover property (ce && ext_clr[0]);
    cov_seq_clear: cover property (ce && acc && wb_adr_i == `IWU_ADR_PER_ASSOC && |per_arm_reg);
    cov_wait_entry: cover property (ce && go_wait);

endmodule

`default_nettype wire

// ==== src/iwu_defines.svh ====
// Register offsets, field positions, reset values and vector constants
`ifndef IWU_DEFINES_SVH
`define IWU_DEFINES_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define IWU_ADR_SENS 8'h00
`define IWU_ADR_PIN_EN 8'h04
`define IWU_ADR_PER_EN 8'h08
`define IWU_ADR_PER_STAT 8'h0c
`define IWU_ADR_PER_ASSOC 8'h10
`define IWU_ADR_STATE 8'h14

// ****************************************************************
// Reset values
// ****************************************************************
`define IWU_RST_SENS 8'h00
`define IWU_RST_PIN_EN 8'h55
`define IWU_RST_PER_EN 6'h00

// ****************************************************************
// Sensitivity codes, two bits per line, line k at bits 2k+1:2k
// ****************************************************************
`define IWU_SENS_FALL_LOW 2'h0
`define IWU_SENS_RISE 2'h1
`define IWU_SENS_FALL 2'h2
`define IWU_SENS_BOTH 2'h3

// ****************************************************************
// Vectors and sources
// ****************************************************************
`define IWU_VEC_RESET 16'hfffe
`define IWU_VEC_TRAP 16'hfffc
`define IWU_VEC_SLOT0 16'hfffa
`define IWU_SRC_TRAP 4'h0
`define IWU_SRC_EXT_FIRST 4'h1
`define IWU_SRC_PER_FIRST 4'h7
`define IWU_SRC_LAST 4'hc
`define IWU_HALT_WAKE_MASK 13'h1a9e

`endif

// ==== src/iwu_pkg.sv ====
// Types shared by the interrupt and wait unit
package iwu_pkg;

    typedef enum logic [1:0] {
        IWU_RUN = 2'h0,
        IWU_WAIT = 2'h1
    } iwu_state_type;

    typedef struct packed {
        logic instr_end;
        logic trap_exec;
        logic wait_for_interrupt_instruction;
        logic i_bit;
    } iwu_cpu_req_type;

    typedef struct packed {
        logic take;
        logic push_condition_code_register;
        logic set_i;
        logic clr_i;
        logic [3:0] source;
        logic [15:0] vector;
    } iwu_svc_type;

endpackage

// ==== verif/iwu_cpu_model.sv ====
// CPU core model: instruction boundaries, trap and wait requests, global mask
`timescale 1ns/1ps
`default_nettype none

module iwu_cpu_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] cpu_cmd,
    input wire logic cpu_stop,
    input wire iwu_pkg::iwu_svc_type svc,
    output var iwu_pkg::iwu_cpu_req_type cpu_req
);
    logic [1:0] cnt_reg;
    logic trap_reg;
    logic wait_req_reg;
    logic i_reg;
    wire logic boundary = (cnt_reg == 2'h3) && !cpu_stop;

    // Four-cycle instructions, frozen while the core is stopped
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= 2'h0;
        end else if (!cpu_stop) begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end

    // Trap and wait requests wait for the next instruction boundary
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trap_reg <= 1'b0;
            wait_req_reg <= 1'b0;
        end else begin
            trap_reg <= cpu_cmd[3] || (trap_reg && !boundary);
            wait_req_reg <= cpu_cmd[2] || (wait_req_reg && !boundary);
        end
    end

    // Global mask: set after reset and on service entry, cleared on wait entry or return
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            i_reg <= 1'b1;
        end else if (svc.set_i || cpu_cmd[1]) begin
            i_reg <= 1'b1;
        end else if (svc.clr_i || cpu_cmd[0]) begin
            i_reg <= 1'b0;
        end
    end

    assign cpu_req.instr_end = boundary;
    assign cpu_req.trap_exec = boundary && trap_reg;
    assign cpu_req.wait_for_interrupt_instruction = boundary && wait_req_reg;
    assign cpu_req.i_bit = i_reg;
endmodule

`default_nettype wire

// ==== verif/iwu_core_test.sv ====
// Self-checking bench for the interrupt and wait unit
`timescale 1ns/1ps
`default_nettype none
`include "iwu_defines.svh"

module iwu_core_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [7:0] pins = 8'hff;
    logic [5:0] pev = 6'h00;
    logic [3:0] cpu_cmd = 4'h0;
    iwu_pkg::iwu_cpu_req_type cpu_req;
    iwu_pkg::iwu_svc_type svc;
    logic cpu_stop;
    logic halt_wake;
    logic [31:0] rd_q[$];
    logic [3:0] src_q[$];
    integer miscompares = 0;
    integer total_checks = 0;
    integer takes = 0;
    integer want = 0;
    integer seed = 20;
    integer c;
    logic [7:0] rnd;

    iwu_core i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_pin_i(pins), .periph_event_i(pev), .cpu_req(cpu_req),
        .svc(svc), .cpu_stop(cpu_stop), .halt_wake(halt_wake));
    iwu_cpu_model i_cpu (.sys_clk(sys_clk), .rst(rst), .cpu_cmd(cpu_cmd),
        .cpu_stop(cpu_stop), .svc(svc), .cpu_req(cpu_req));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // Checking and driving tasks
    // ****************************************************************
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_svc(input iwu_pkg::iwu_svc_type got, input logic [3:0] s);
        logic [23:0] exp;
        logic [15:0] vec;
        vec = (s == 4'h0) ? `IWU_VEC_TRAP : `IWU_VEC_SLOT0 - {11'h0, s, 1'b0};
        exp = {4'he, s, vec};
        total_checks = total_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e);
        integer n;
        @(posedge sys_clk);
        if (!w) rd_q.push_back(e);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n = n + 1;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) miscompares = miscompares + 1;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic pulse_cmd(input logic [3:0] m);
        @(posedge sys_clk);
        cpu_cmd <= m;
        @(posedge sys_clk);
        cpu_cmd <= 4'h0;
    endtask

    task automatic pulse_ev(input logic [5:0] m);
        @(posedge sys_clk);
        pev <= m;
        @(posedge sys_clk);
        pev <= 6'h0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic set_pins(input logic [7:0] v);
        @(posedge sys_clk);
        pins <= v;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic take_one(input logic [3:0] s);
        integer n;
        src_q.push_back(s);
        want = want + 1;
        pulse_cmd(4'h1);
        n = 0;
        while (takes < want && n < 100) begin
            @(posedge sys_clk);
            n = n + 1;
        end
        cmp_word(takes, want);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Result watcher: every read and every service entry consumes the oldest note
    always @(posedge sys_clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            cmp_word(rdat, rd_q.size() > 0 ? rd_q.pop_front() : 32'hdeadbeef);
        end
        if (svc.take === 1'b1) begin
            takes = takes + 1;
            cmp_svc(svc, src_q.size() > 0 ? src_q.pop_front() : 4'hf);
        end
    end

    initial begin
        #300000;
        miscompares = miscompares + 1;
        end_sim();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        wb_io(1'b0, `IWU_ADR_SENS, 32'h0, 32'h0);
        wb_io(1'b0, `IWU_ADR_PIN_EN, 32'h0, 32'h55);
        wb_io(1'b0, `IWU_ADR_PER_EN, 32'h0, 32'h0);
        wb_io(1'b0, 8'hf0, 32'h0, 32'h0);
        rnd = 8'($random(seed));
        wb_io(1'b1, `IWU_ADR_SENS, {24'h0, rnd}, 32'h0);
        wb_io(1'b0, `IWU_ADR_SENS, 32'h0, {24'h0, rnd});
        pulse_cmd(4'h1);
        wb_io(1'b1, `IWU_ADR_SENS, {24'h0, ~rnd}, 32'h0);
        wb_io(1'b0, `IWU_ADR_SENS, 32'h0, {24'h0, rnd});
        pulse_cmd(4'h2);
        $display("test registers done");
        for (c = 0; c < 4; c++) begin
            wb_io(1'b1, `IWU_ADR_SENS, c, 32'h0);
            set_pins(8'hfe);
            wb_io(1'b0, `IWU_ADR_STATE, 32'h0, 32'h20 | (c != 1));
            set_pins(8'hff);
            wb_io(1'b0, `IWU_ADR_STATE, 32'h0, 32'h21);
            take_one(4'h1);
            wb_io(1'b0, `IWU_ADR_STATE, 32'h0, 32'h20);
        end
        $display("test sensitivity done");
        wb_io(1'b1, `IWU_ADR_PIN_EN, 32'h5d, 32'h0);
        wb_io(1'b1, `IWU_ADR_SENS, 32'h04, 32'h0);
        set_pins(8'hf7);
        set_pins(8'hf3);
        set_pins(8'hf7);
        wb_io(1'b0, `IWU_ADR_STATE, 32'h0, 32'h20);
        set_pins(8'hff);
        wb_io(1'b0, `IWU_ADR_STATE, 32'h0, 32'h22);
        take_one(4'h2);
        $display("test combined pins done");
        wb_io(1'b1, `IWU_ADR_SENS, 32'h80, 32'h0);
        wb_io(1'b1, `IWU_ADR_PER_EN, 32'h3f, 32'h0);
        pulse_ev(6'h3f);
        set_pins(8'hbf);
        take_one(4'h4);
        for (c = 0; c < 6; c++) begin
            take_one(4'(7 + c));
            wb_io(1'b1, `IWU_ADR_PER_STAT, ~(32'h1 << c), 32'h0);
        end
        wb_io(1'b0, `IWU_ADR_PER_STAT, 32'h0, 32'h0);
        $display("test priority done");
        pulse_ev(6'h02);
        cmp_word(32'(halt_wake), 32'h0);
        pulse_ev(6'h08);
        cmp_word(32'(halt_wake), 32'h0);
        pulse_ev(6'h04);
        cmp_word(32'(halt_wake), 32'h1);
        wb_io(1'b1, `IWU_ADR_PER_EN, 32'h0, 32'h0);
        pulse_cmd(4'h1);
        repeat (20) @(posedge sys_clk);
        wb_io(1'b0, `IWU_ADR_PER_STAT, 32'h0, 32'h0e);
        pulse_cmd(4'h2);
        wb_io(1'b0, `IWU_ADR_PER_STAT, 32'h0, 32'h0e);
        wb_io(1'b0, `IWU_ADR_PER_ASSOC, 32'h0, 32'h0);
        wb_io(1'b0, `IWU_ADR_PER_STAT, 32'h0, 32'h0);
        $display("test pending done");
        src_q.push_back(4'h0);
        want = want + 1;
        pulse_cmd(4'h8);
        repeat (12) @(posedge sys_clk);
        cmp_word(takes, want);
        wb_io(1'b1, `IWU_ADR_PER_EN, 32'h20, 32'h0);
        pulse_cmd(4'h4);
        repeat (12) @(posedge sys_clk);
        cmp_word(32'(cpu_stop), 32'h1);
        wb_io(1'b0, `IWU_ADR_STATE, 32'h0, 32'h10);
        src_q.push_back(4'hc);
        want = want + 1;
        pulse_ev(6'h20);
        cmp_word(takes, want);
        cmp_word(32'(cpu_stop), 32'h0);
        $display("test trap and wait done");
        ce <= 1'b0;
        set_pins(8'hfe);
        set_pins(8'hff);
        ce <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wb_io(1'b0, `IWU_ADR_STATE, 32'h0, 32'h20);
        $display("test clock enable done");
        end_sim();
    end
endmodule

`default_nettype wire
